/* rtl/timer_pkg.sv */
package timer_pkg;
  // ==========================================
  // host port map
  localparam int ADDR_W = 5;
  localparam int NUM_CH = 3;
  localparam logic [4:0] OFS_CNT0 = 5'h14;
  localparam logic [4:0] OFS_CNT1 = 5'h15;
  localparam logic [4:0] OFS_CNT2 = 5'h16;
  localparam logic [4:0] OFS_CTRL = 5'h17;
  localparam logic [7:0] READ_IDLE = 8'h00;
  // ==========================================
  // control byte fields
  localparam int SEL_LO = 6;
  localparam int AM_LO = 4;
  localparam int MODE_LO = 1;
  localparam int BCD_BIT = 0;
  localparam int RB_CNT_N = 5;
  localparam int RB_STA_N = 4;
  localparam int RB_PICK_LO = 1;
  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] AM_LATCH = 2'h0;
  localparam logic [1:0] AM_LOW = 2'h1;
  localparam logic [1:0] AM_HIGH = 2'h2;
  localparam logic [1:0] AM_PAIR = 2'h3;
  localparam logic [2:0] MODE_SW_STROBE = 3'h4;
  localparam logic [2:0] MODE_HW_STROBE = 3'h5;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [15:0] ZERO_COUNT = 16'h0000;
  // ==========================================
  // state
  typedef struct packed {
    logic [15:0] cr;
    logic [15:0] ce;
    logic [15:0] ol;
    logic [7:0]  status;
    logic [1:0]  am;
    logic [2:0]  mode;
    logic        bcd;
    logic        out_low;
    logic        nul;
    logic        armed;
    logic        load_pend;
    logic        trig_pend;
    logic        have_count;
    logic        latched;
    logic        st_latched;
    logic        wtog;
    logic        rtog;
    logic        gate_prev;
  } chan_s;
  typedef struct packed {
    chan_s [NUM_CH-1:0] ch;
    logic [7:0]         rd_data;
    logic               tick_prev;
    logic               out1_prev;
  } state_s;
endpackage : timer_pkg

/* rtl/triple_down_counter_timer.sv */
module triple_down_counter_timer
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         resetn,
  // host byte port
  input  wire logic [timer_pkg::ADDR_W-1:0] addr,
  input  wire logic                         wr_en,
  input  wire logic                         rd_en,
  input  wire logic [7:0]                   wr_data,
  output logic      [7:0]                   rd_data,
  // counter pins
  input  wire logic                         tick_10mhz,
  input  wire logic [timer_pkg::NUM_CH-1:0] gate_in,
  output logic      [timer_pkg::NUM_CH-1:0] cnt_out
);
  import timer_pkg::*;

  // ==========================================
  // helpers
  function automatic logic [15:0] count_down(
    input logic [15:0] v,
    input logic        bcd
  );
    logic [15:0] r;
    logic        borrow;
    r = v - 16'h0001;
    borrow = 1'b1;
    if (bcd)
    begin
      for (int d = 0; d < 4; d++)
      begin
        r[d*4 +: 4] = v[d*4 +: 4];
        if (borrow)
        begin
          if (v[d*4 +: 4] == 4'h0)
            r[d*4 +: 4] = BCD_NINE;
          else
          begin
            r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : count_down

  function automatic logic [ADDR_W-1:0] port_of(input int i);
    return OFS_CNT0 + ADDR_W'(i);
  endfunction : port_of

  // ==========================================
  // decode
  state_s s_reg;
  state_s s_next;
  logic              tick_rise;
  logic              ctl_wr;
  logic              rb_cmd;
  logic [NUM_CH-1:0] ch_tick;
  logic [NUM_CH-1:0] ctl_prog;
  logic [NUM_CH-1:0] latch_cmd;
  logic [NUM_CH-1:0] stat_cmd;
  logic [NUM_CH-1:0] port_wr;
  logic [NUM_CH-1:0] port_rd;

  assign tick_rise = tick_10mhz & ~s_reg.tick_prev;
  assign ctl_wr = wr_en && addr == OFS_CTRL;
  assign rb_cmd = ctl_wr
    && wr_data[SEL_LO +: 2] == SEL_READBACK;

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_dec
    // counter 2 steps on counter 1 output rising, counting counter 1's one-shot strobes
    if (i == 2)
    begin : g_casc
      assign ch_tick[i] = ~s_reg.ch[1].out_low & s_reg.out1_prev;
    end
    else
    begin : g_tick
      assign ch_tick[i] = tick_rise;
    end
    assign ctl_prog[i] = ctl_wr
      && wr_data[SEL_LO +: 2] == 2'(i)
      && wr_data[AM_LO +: 2] != AM_LATCH;
    assign latch_cmd[i] = (ctl_wr
      && wr_data[SEL_LO +: 2] == 2'(i)
      && wr_data[AM_LO +: 2] == AM_LATCH)
      || (rb_cmd && !wr_data[RB_CNT_N]
      && wr_data[RB_PICK_LO + i]);
    assign stat_cmd[i] = rb_cmd && !wr_data[RB_STA_N]
      && wr_data[RB_PICK_LO + i];
    assign port_wr[i] = wr_en && addr == port_of(i);
    assign port_rd[i] = rd_en && addr == port_of(i);
    assign cnt_out[i] = ~s_reg.ch[i].out_low;
  end

  assign rd_data = s_reg.rd_data;

  // ==========================================
  // next state
  always_comb
  begin
    logic [15:0] src;
    logic [15:0] dn;
    src = ZERO_COUNT;
    dn = ZERO_COUNT;
    s_next = s_reg;
    s_next.tick_prev = tick_10mhz;
    // keep counter 1's low flag, so the reset value matches its idle high
    s_next.out1_prev = s_reg.ch[1].out_low;
    if (rd_en)
      s_next.rd_data = READ_IDLE;
    for (int i = 0; i < NUM_CH; i++)
    begin
      // counting element, one step per input tick
      if (ch_tick[i])
      begin
        dn = count_down(s_reg.ch[i].ce, s_reg.ch[i].bcd);
        s_next.ch[i].out_low = 1'b0;
        if (s_reg.ch[i].mode == MODE_HW_STROBE
            && s_reg.ch[i].trig_pend && s_reg.ch[i].have_count)
        begin
          s_next.ch[i].ce = s_reg.ch[i].cr;
          s_next.ch[i].nul = 1'b0;
          s_next.ch[i].armed = 1'b1;
          s_next.ch[i].trig_pend = 1'b0;
        end
        else if (s_reg.ch[i].mode == MODE_SW_STROBE
                 && s_reg.ch[i].load_pend)
        begin
          s_next.ch[i].ce = s_reg.ch[i].cr;
          s_next.ch[i].nul = 1'b0;
          s_next.ch[i].armed = 1'b1;
          s_next.ch[i].load_pend = 1'b0;
        end
        else if (s_reg.ch[i].armed
                 && (s_reg.ch[i].mode == MODE_HW_STROBE
                     || gate_in[i]))
        begin
          s_next.ch[i].ce = dn;
          if (dn == ZERO_COUNT)
          begin
            // strobe once, then stay idle until reload
            s_next.ch[i].out_low = 1'b1;
            s_next.ch[i].armed = 1'b0;
          end
        end
      end
      // gate edge after the tick so a same-cycle trigger is kept
      s_next.ch[i].gate_prev = gate_in[i];
      if (gate_in[i] && !s_reg.ch[i].gate_prev
          && s_reg.ch[i].mode == MODE_HW_STROBE)
        s_next.ch[i].trig_pend = 1'b1;
      // control byte
      if (ctl_prog[i])
      begin
        s_next.ch[i].am = wr_data[AM_LO +: 2];
        s_next.ch[i].mode = wr_data[MODE_LO +: 3];
        s_next.ch[i].bcd = wr_data[BCD_BIT];
        s_next.ch[i].out_low = 1'b0;
        s_next.ch[i].armed = 1'b0;
        s_next.ch[i].load_pend = 1'b0;
        s_next.ch[i].trig_pend = 1'b0;
        s_next.ch[i].have_count = 1'b0;
        s_next.ch[i].nul = 1'b1;
        s_next.ch[i].latched = 1'b0;
        s_next.ch[i].st_latched = 1'b0;
        s_next.ch[i].wtog = 1'b0;
        s_next.ch[i].rtog = 1'b0;
      end
      if (latch_cmd[i] && !s_reg.ch[i].latched)
      begin
        s_next.ch[i].ol = s_reg.ch[i].ce;
        s_next.ch[i].latched = 1'b1;
      end
      if (stat_cmd[i] && !s_reg.ch[i].st_latched)
      begin
        s_next.ch[i].status = {~s_reg.ch[i].out_low,
          s_reg.ch[i].nul, s_reg.ch[i].am,
          s_reg.ch[i].mode, s_reg.ch[i].bcd};
        s_next.ch[i].st_latched = 1'b1;
      end
      // count write; a pair completes on the high byte
      if (port_wr[i])
      begin
        if (s_reg.ch[i].am == AM_HIGH
            || (s_reg.ch[i].am == AM_PAIR && s_reg.ch[i].wtog))
          s_next.ch[i].cr[15:8] = wr_data;
        else
          s_next.ch[i].cr[7:0] = wr_data;
        if (s_reg.ch[i].am == AM_PAIR)
          s_next.ch[i].wtog = ~s_reg.ch[i].wtog;
        if (s_reg.ch[i].am != AM_PAIR || s_reg.ch[i].wtog)
        begin
          s_next.ch[i].nul = 1'b1;
          s_next.ch[i].have_count = 1'b1;
          if (s_reg.ch[i].mode == MODE_SW_STROBE)
          begin
            s_next.ch[i].load_pend = 1'b1;
            s_next.ch[i].armed = 1'b0;
          end
        end
      end
      // count read: status first, then held or live count
      if (port_rd[i])
      begin
        src = s_reg.ch[i].latched ? s_reg.ch[i].ol
                                  : s_reg.ch[i].ce;
        if (s_reg.ch[i].st_latched)
        begin
          s_next.rd_data = s_reg.ch[i].status;
          s_next.ch[i].st_latched = 1'b0;
        end
        else if (s_reg.ch[i].am == AM_PAIR)
        begin
          s_next.rd_data = s_reg.ch[i].rtog ? src[15:8]
                                            : src[7:0];
          s_next.ch[i].rtog = ~s_reg.ch[i].rtog;
          if (s_reg.ch[i].rtog)
            s_next.ch[i].latched = 1'b0;
        end
        else
        begin
          s_next.rd_data = s_reg.ch[i].am == AM_HIGH ? src[15:8]
                                                     : src[7:0];
          s_next.ch[i].latched = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_chk
    pulse_end_a : assert property (
      ch_tick[i] && s_reg.ch[i].out_low && !ctl_prog[i]
      |=> !s_reg.ch[i].out_low)
      else $error("strobe longer than one tick");
    pulse_zero_a : assert property (
      $rose(s_reg.ch[i].out_low)
      |-> s_reg.ch[i].ce == ZERO_COUNT && !s_reg.ch[i].armed)
      else $error("strobe not at terminal count");
    gate_hold_a : assert property (
      ch_tick[i] && s_reg.ch[i].mode == MODE_SW_STROBE
      && !gate_in[i] && !s_reg.ch[i].load_pend && !wr_en
      |=> $stable(s_reg.ch[i].ce))
      else $error("count moved with gate low");
    retrigger_a : assert property (
      ch_tick[i] && s_reg.ch[i].mode == MODE_HW_STROBE
      && s_reg.ch[i].trig_pend && s_reg.ch[i].have_count && !wr_en
      |=> s_reg.ch[i].ce == $past(s_reg.ch[i].cr)
      && s_reg.ch[i].armed && !s_reg.ch[i].out_low)
      else $error("trigger did not reload count");
    latch_copy_a : assert property (
      latch_cmd[i] && !s_reg.ch[i].latched
      |=> s_reg.ch[i].latched
      && s_reg.ch[i].ol == $past(s_reg.ch[i].ce))
      else $error("latch did not capture count");
    latch_ignore_a : assert property (
      latch_cmd[i] && s_reg.ch[i].latched
      |=> $stable(s_reg.ch[i].ol))
      else $error("second latch overwrote hold");
    null_set_a : assert property (
      port_wr[i] && !ctl_prog[i]
      && (s_reg.ch[i].am != AM_PAIR || s_reg.ch[i].wtog)
      |=> s_reg.ch[i].nul && s_reg.ch[i].have_count)
      else $error("null count not set by write");
    status_first_a : assert property (
      port_rd[i] && s_reg.ch[i].st_latched
      |=> rd_data == $past(s_reg.ch[i].status)
      && !s_reg.ch[i].st_latched)
      else $error("status not returned first");
    status_byte_a : assert property (
      stat_cmd[i] && !s_reg.ch[i].st_latched
      |=> s_reg.ch[i].status[7] == !$past(s_reg.ch[i].out_low)
      && s_reg.ch[i].status[5:4] == s_reg.ch[i].am)
      else $error("status byte wrong");
    ctl_reset_a : assert property (
      ctl_prog[i]
      |=> !s_reg.ch[i].latched && !s_reg.ch[i].wtog
      && !s_reg.ch[i].rtog && s_reg.ch[i].nul
      && s_reg.ch[i].mode == $past(wr_data[MODE_LO +: 3]))
      else $error("control byte did not reset counter");
    load_move_a : assert property (
      ch_tick[i] && s_reg.ch[i].mode == MODE_SW_STROBE
      && s_reg.ch[i].load_pend && !wr_en
      |=> s_reg.ch[i].ce == $past(s_reg.ch[i].cr)
      && s_reg.ch[i].armed && !s_reg.ch[i].nul)
      else $error("load did not reach counting element");
    no_strobe_a : assert property (
      ch_tick[i] && !s_reg.ch[i].armed && !s_reg.ch[i].load_pend
      && !s_reg.ch[i].trig_pend
      |=> !s_reg.ch[i].out_low)
      else $error("strobe without a loaded count");
  end

  // counter 2 must step on every rising edge of counter 1's output
  cascade_tick_a : assert property (
    $rose(cnt_out[1]) |-> ch_tick[2])
    else $error("counter 2 missed a cascade edge");
  read_idle_a : assert property (
    rd_en && port_rd == '0 |=> rd_data == READ_IDLE)
    else $error("unmapped read not idle");

  sw_strobe_c : cover property (
    s_reg.ch[0].mode == MODE_SW_STROBE
    && $rose(s_reg.ch[0].out_low));
  hw_retrig_c : cover property (
    s_reg.ch[0].armed && s_reg.ch[0].trig_pend
    ##[1:100] $rose(s_reg.ch[0].out_low));
  cascade_c : cover property (
    ch_tick[2] && s_reg.ch[2].armed
    ##1 $rose(s_reg.ch[2].out_low));
  stat_then_count_c : cover property (
    port_rd[0] && s_reg.ch[0].st_latched && s_reg.ch[0].latched
    ##1 port_rd[0] ##1 port_rd[0]);
endmodule : triple_down_counter_timer

/* sim/tick_source.sv */
module tick_source
(
  // clock
  input  wire logic clk,
  // pacer tick
  output logic      tick
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // pacer
  // 12 clk per tick stands in for the 10 MHz pacer: an integral period
  // keeps every strobe of counters 0 and 1 exactly the same length
  localparam int HALF = 6;
  int unsigned n = 0;
  initial tick = 1'b0;
  always @(negedge clk)
  begin
    n <= (n == HALF - 1) ? 0 : n + 1;
    if (n == HALF - 1)
      tick <= ~tick;
  end
endmodule : tick_source

/* sim/triple_down_counter_timer_tb_top.sv */
module triple_down_counter_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;
  localparam int TICK_CLK = 12;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0]        wr_data = 8'h00;
  logic [7:0]        rd_data;
  logic [7:0]        d;
  logic              tick;
  logic              tprev = 1'b0;
  logic [NUM_CH-1:0] gate_in = 3'h7;
  logic [NUM_CH-1:0] cnt_out;
  int                n_errors = 0;
  int                check_count = 0;
  int                rises = 0;
  int                cycles = 0;
  // ==========================================
  // structure
  triple_down_counter_timer dut (.clk(clk), .resetn(resetn), .addr(addr),
    .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data),
    .tick_10mhz(tick), .gate_in(gate_in), .cnt_out(cnt_out));
  tick_source pacer (.clk(clk), .tick(tick));
  initial
  begin
    forever #4 clk = ~clk;
  end
  // tick edges counted where tick is settled
  always @(posedge clk)
  begin
    tprev <= tick;
    cycles <= cycles + 1;
    if (tick && !tprev)
      rises <= rises + 1;
    if (cycles == 40000)
    begin
      n_errors++;
      summarize();
    end
  end
  // ==========================================
  // tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    addr = a;
    wr_data = v;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    v = rd_data;
    @(negedge clk);
  endtask : rd
  // low then high, always as a pair so the toggle stays in step
  task automatic rd16(input logic [4:0] a, input logic [15:0] exp);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a, hi);
    chk({hi, lo}, exp);
  endtask : rd16
  task automatic wait_ticks(input int n);
    int r;
    r = rises;
    while (rises < r + n)
      @(negedge clk);
    repeat (3) @(negedge clk);
  endtask : wait_ticks
  // ticks until the strobe, then the strobe's length
  task automatic strobe(input int ch, input int exp);
    int r;
    int k;
    r = rises;
    k = 0;
    while (cnt_out[ch] !== 1'b0 && k < 600)
    begin
      @(negedge clk);
      k++;
    end
    chk(16'(rises - r), 16'(exp));
    k = 0;
    while (cnt_out[ch] === 1'b0 && k < 100)
    begin
      @(negedge clk);
      k++;
    end
    chk(16'(k), 16'(TICK_CLK));
  endtask : strobe
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // ==========================================
  // tests
  initial
  begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    chk({8'h00, rd_data}, 16'h0000);
    chk({13'h0, cnt_out}, 16'h0007);
    wr(OFS_CTRL, 8'h38);
    wr(OFS_CTRL, 8'hE2);
    rd(OFS_CNT0, d);
    chk({8'h00, d}, 16'h00F8);
    wr(OFS_CNT0, 8'h03);
    wr(OFS_CNT0, 8'h00);
    strobe(0, 4);
    wait_ticks(5);
    chk({15'h0, cnt_out[0]}, 16'h0001);
    wr(OFS_CTRL, 8'hE2);
    rd(OFS_CNT0, d);
    chk({8'h00, d}, 16'h00B8);
    gate_in[0] = 1'b0;
    wr(OFS_CNT0, 8'h02);
    wr(OFS_CNT0, 8'h00);
    wait_ticks(4);
    chk({15'h0, cnt_out[0]}, 16'h0001);
    gate_in[0] = 1'b1;
    strobe(0, 2);
    gate_in[1] = 1'b0;
    wr(OFS_CTRL, 8'h7A);
    wr(OFS_CNT1, 8'h03);
    wr(OFS_CNT1, 8'h00);
    wait_ticks(5);
    chk({15'h0, cnt_out[1]}, 16'h0001);
    gate_in[1] = 1'b1;
    strobe(1, 4);
    gate_in[1] = 1'b0;
    wait_ticks(1);
    gate_in[1] = 1'b1;
    wait_ticks(2);
    gate_in[1] = 1'b0;
    @(negedge clk);
    gate_in[1] = 1'b1;
    strobe(1, 4);
    gate_in[0] = 1'b0;
    wr(OFS_CTRL, 8'h38);
    wr(OFS_CNT0, 8'h34);
    wr(OFS_CNT0, 8'h12);
    wait_ticks(2);
    wr(OFS_CTRL, 8'h00);
    gate_in[0] = 1'b1;
    wait_ticks(3);
    wr(OFS_CTRL, 8'h00);
    gate_in[0] = 1'b0;
    rd16(OFS_CNT0, 16'h1234);
    rd16(OFS_CNT0, 16'h1231);
    wr(OFS_CTRL, 8'hC2);
    rd(OFS_CNT0, d);
    chk({8'h00, d}, 16'h00B8);
    rd16(OFS_CNT0, 16'h1231);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CTRL, 8'hE2);
    rd(OFS_CNT0, d);
    chk({8'h00, d}, 16'h00B8);
    rd16(OFS_CNT0, 16'h1231);
    wr(OFS_CTRL, 8'hDE);
    gate_in[0] = 1'b1;
    wait_ticks(1);
    gate_in[0] = 1'b0;
    rd16(OFS_CNT0, 16'h1231);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CTRL, 8'h18);
    wr(OFS_CNT0, 8'h56);
    wait_ticks(1);
    rd(OFS_CNT0, d);
    chk({8'h00, d}, 16'h0056);
    wr(OFS_CTRL, 8'h28);
    wr(OFS_CNT0, 8'hAB);
    wait_ticks(1);
    rd(OFS_CNT0, d);
    chk({8'h00, d}, 16'h00AB);
    wr(OFS_CTRL, 8'hE2);
    rd(OFS_CNT0, d);
    chk({8'h00, d}, 16'h00A8);
    wr(OFS_CTRL, 8'h39);
    gate_in[0] = 1'b1;
    wr(OFS_CNT0, 8'h10);
    wr(OFS_CNT0, 8'h00);
    strobe(0, 11);
    for (int m = 0; m < 6; m++)
    begin
      wr(OFS_CTRL, {2'h2, AM_LOW, 3'(m), 1'b0});
      wr(OFS_CTRL, 8'hE8);
      rd(OFS_CNT2, d);
      chk({8'h00, d}, {8'h00, 4'hD, 3'(m), 1'b0});
    end
    // counter 1 strobes clock counter 2: first edge loads, second strobes
    wr(OFS_CTRL, 8'hB8);
    wr(OFS_CNT2, 8'h01);
    wr(OFS_CNT2, 8'h00);
    for (int t = 0; t < 2; t++)
    begin
      gate_in[1] = 1'b0;
      @(negedge clk);
      gate_in[1] = 1'b1;
      @(negedge clk);
      strobe(1, 4);
      repeat (2) @(negedge clk);
      chk({15'h0, cnt_out[2]}, 16'(1 - t));
    end
    rd(OFS_CTRL, d);
    chk({8'h00, d}, 16'h0000);
    rd(5'h10, d);
    chk({8'h00, d}, 16'h0000);
    summarize();
  end
endmodule : triple_down_counter_timer_tb_top
